// File: cio_port.v
// configurable i/o port: config registers, latches, pad controls
module cio_port (
	input wire clk,
	input wire reset,
	input wire cfg_we,
	input wire [1:0] cfg_port,
	input wire [7:0] cfg0_wdata,
	input wire [7:0] cfg1_wdata,
	input wire latch_we,
	input wire [1:0] latch_port,
	input wire [7:0] latch_wdata,
	input wire dis_we,
	input wire [7:0] dis_wdata,
	input wire [31:0] pin_in,
	input wire three_port,
	input wire ext_clock_in,
	input wire crystal,
	input wire ext_reset_en,
	output reg [31:0] pin_oe,
	output reg [31:0] pin_out,
	output reg [31:0] pin_weak_hi,
	output reg [31:0] pin_rd,
	output reg [31:0] cfg0_rd,
	output reg [31:0] cfg1_rd,
	output reg [7:0] port0_digital_input_disable,
	output reg [3:0] io_pin_count
);
`include "cio_regs.vh"
	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [31:0] cfg0_q; // low config bit per pin
	reg [31:0] cfg1_q; // high config bit per pin
	reg [31:0] latch_q; // output latches
	reg [31:0] cfg0_d;
	reg [31:0] cfg1_d;
	wire [31:0] s_hi; // strong high per pin
	wire [31:0] w_hi; // weak high per pin
	wire [31:0] s_lo; // strong low per pin
	wire [3:0] cnt;
	integer i;
	// ----------------------------------------
	// restrict a requested type for special pins
	// ----------------------------------------
	function [1:0] legal_type;
		input integer pin;
		input [1:0] want;
		begin
			legal_type = want;
			if (pin == `CIO_RST_PIN)
				legal_type = `CIO_INPUT;
			else if (pin == `CIO_T0_PIN && want != `CIO_OPEN)
				legal_type = `CIO_INPUT;
		end
	endfunction
	// ----------------------------------------
	// next config: write lands on one port's byte
	// ----------------------------------------
	// two registers per port
	always @* begin
		cfg0_d = cfg0_q;
		cfg1_d = cfg1_q;
		if (cfg_we) begin
			for (i = 0; i < `CIO_PINS; i = i + 1) begin
				{cfg1_d[cfg_port*8+i], cfg0_d[cfg_port*8+i]} =
					legal_type(cfg_port*8+i, {cfg1_wdata[i], cfg0_wdata[i]});
			end
		end
	end
	// ----------------------------------------
	// registers
	// ----------------------------------------
	// input-only after reset
	always @(posedge clk) begin
		if (reset) begin
			cfg0_q <= `CIO_CFG0_RST;
			cfg1_q <= `CIO_CFG1_RST;
			latch_q <= `CIO_LATCH_RST;
		end else begin
			cfg0_q <= cfg0_d;
			cfg1_q <= cfg1_d;
			if (latch_we)
				latch_q[latch_port*8 +: 8] <= latch_wdata;
		end
	end
	always @(posedge clk) begin
		if (reset)
			port0_digital_input_disable <= `CIO_DIS_RST;
		else if (dis_we)
			port0_digital_input_disable <= dis_wdata;
	end
	// ----------------------------------------
	// per pin drivers
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `CIO_W; g = g + 1) begin : gen_pin
			cio_pin_driver u_drv (
				.cfg({cfg1_q[g], cfg0_q[g]}),
				.latch(latch_q[g]),
				.strong_hi(s_hi[g]),
				.weak_hi(w_hi[g]),
				.strong_lo(s_lo[g])
			);
		end
	endgenerate
	// pin count by options
	cio_pin_count u_cnt (
		.three_port(three_port),
		.ext_clock_in(ext_clock_in),
		.crystal(crystal),
		.ext_reset_en(ext_reset_en),
		.count(cnt)
	);
	// ----------------------------------------
	// registered outputs; weak high is a pull, not a drive
	// ----------------------------------------
	always @(posedge clk) begin
		if (reset) begin
			pin_oe <= 32'h00000000;
			pin_out <= 32'h00000000;
			pin_weak_hi <= 32'h00000000;
			pin_rd <= 32'h00000000;
			cfg0_rd <= `CIO_CFG0_RST;
			cfg1_rd <= `CIO_CFG1_RST;
			io_pin_count <= 4'h0;
		end else begin
			pin_oe <= s_hi | s_lo;
			pin_out <= s_hi;
			pin_weak_hi <= w_hi;
			pin_rd <= {pin_in[31:8], pin_in[7:0] & ~port0_digital_input_disable};
			cfg0_rd <= cfg0_q;
			cfg1_rd <= cfg1_q;
			io_pin_count <= cnt;
		end
	end
endmodule // cio_port

// File: cio_regs.vh
// constants of the configurable i/o port
`ifndef CIO_REGS_VH
`define CIO_REGS_VH
// Function
// - four driver types selectable per pin
// - two config registers per port select type
// - reset shared pin always input only
// - timer0 pin only input-only or open-drain
// - quasi mode: weak high, strong low
// - open-drain: no pull-up, low on zero
// - input-only: all drivers off, input readable
// - push-pull: strong low and strong high
// - port0 digital input disable, cleared on reset
// - all pins input-only after power-up
// - four-port pin count twelve down to nine
// - three-port pin count twelve or eleven
// ----------------------------------------
// geometry
// ----------------------------------------
`define CIO_PORTS 4
`define CIO_PINS 8
`define CIO_W 32
// ----------------------------------------
// driver type encoding {cfg1,cfg0}
// ----------------------------------------
`define CIO_QUASI 2'h0
`define CIO_PUSH 2'h1
`define CIO_INPUT 2'h2
`define CIO_OPEN 2'h3
// ----------------------------------------
// reset values and special pin positions
// ----------------------------------------
`define CIO_CFG0_RST 32'h00000000
`define CIO_CFG1_RST 32'hFFFFFFFF
`define CIO_LATCH_RST 32'hFFFFFFFF
`define CIO_DIS_RST 8'h00
`define CIO_RST_PIN 13
`define CIO_T0_PIN 10
`define CIO_BASE_PINS 4'hC
`endif

// File: cio_pin_driver.v
// one pin's driver decode: type and latch to pad controls
module cio_pin_driver (
	input wire [1:0] cfg,
	input wire latch,
	output reg strong_hi,
	output reg weak_hi,
	output reg strong_lo
);
`include "cio_regs.vh"
	// ----------------------------------------
	// driver decode
	// ----------------------------------------
	// four type decode
	always @* begin
		strong_hi = 1'b0;
		weak_hi = 1'b0;
		strong_lo = 1'b0;
		case (cfg)
			`CIO_QUASI: begin
				weak_hi = latch;
				strong_lo = ~latch;
			end
			`CIO_PUSH: begin
				strong_hi = latch;
				strong_lo = ~latch;
			end
			`CIO_OPEN: begin
				strong_lo = ~latch;
			end
			default: begin
				strong_lo = 1'b0;
			end
		endcase
	end
endmodule // cio_pin_driver

// File: cio_pin_count.v
// usable general i/o pin count from clock and reset options
module cio_pin_count (
	input wire three_port,
	input wire ext_clock_in,
	input wire crystal,
	input wire ext_reset_en,
	output wire [3:0] count
);
`include "cio_regs.vh"
	// ----------------------------------------
	// each external clock pin costs one on four port only; the reset pin costs one on both
	// ----------------------------------------
	wire [3:0] clk_cost;
	wire [3:0] rst_cost;
	assign clk_cost = three_port ? 4'h0 : (crystal ? 4'h2 : (ext_clock_in ? 4'h1 : 4'h0));
	// reset pin costs one on both three port and four port
	assign rst_cost = ext_reset_en ? 4'h1 : 4'h0;
	assign count = `CIO_BASE_PINS - clk_cost - rst_cost;
endmodule // cio_pin_count

// File: cio_pad.sv
// pad partner: outside parts on the port pins
module cio_pad (
	input wire [31:0] pin_oe,
	input wire [31:0] pin_out,
	output wire [31:0] pin_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// pins 3:0 pulled low outside, pull-up elsewhere; strong drive wins
	assign pin_in = pin_oe & pin_out | ~pin_oe & 32'hFFFFFFF0;
endmodule // cio_pad

// File: cio_port_asserts.sv
// pad control checker of the configurable port
module cio_chk (
	input wire clk,
	input wire reset,
	input wire [31:0] pin_oe,
	input wire [31:0] pin_out,
	input wire [31:0] pin_weak_hi,
	input wire [31:0] cfg0_rd,
	input wire [31:0] cfg1_rd
);
	// driver type of pin 0
	wire [1:0] ty = {cfg1_rd[0], cfg0_rd[0]};
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	a_rst_pin: assert property (!pin_oe[13] && !pin_weak_hi[13]) else $error("rst pin");
	a_t0_pin: assert property (!pin_weak_hi[10] && !(pin_oe[10] && pin_out[10]))
		else $error("t0 pin");
	a_quasi_weak: assert property (ty == 2'h0 |-> pin_weak_hi[0] != pin_oe[0]) else $error("q");
	a_strong_low: assert property (ty != 2'h1 && pin_oe[0] |-> !pin_out[0]) else $error("lo");
	a_open_no_up: assert property (ty == 2'h3 |-> !pin_weak_hi[0]) else $error("open");
	a_input_off: assert property (ty == 2'h2 |-> !pin_oe[0] && !pin_weak_hi[0]) else $error("in");
	a_push_on: assert property (ty == 2'h1 |-> pin_oe[0] && !pin_weak_hi[0]) else $error("pp");
	a_boot_input: assert property ($past(reset) |-> cfg1_rd == 32'hFFFFFFFF && cfg0_rd == 32'h0)
		else $error("boot");
endmodule // cio_chk
bind cio_port cio_chk u_chk (.clk, .reset, .pin_oe, .pin_out, .pin_weak_hi, .cfg0_rd, .cfg1_rd);

// File: cio_port_bench.sv
// bench of the configurable port
module cio_port_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, reset = 1, cw = 0, lw = 0, dw = 0;
	logic [1:0] cp = 2'h0;
	logic [7:0] c0 = 8'h0, c1 = 8'h0, la = 8'h0, ds = 8'h0, dr;
	logic [3:0] op = 4'h0, cnt;
	logic [31:0] pin_in, oe, out, wk, rd, r0, r1;
	int failures = 0, n_compared = 0;
	always #12.5 clk = ~clk;
	cio_pad u_pad (.pin_oe(oe), .pin_out(out), .pin_in);
	cio_port DUT (.clk, .reset, .cfg_we(cw), .cfg_port(cp), .cfg0_wdata(c0), .cfg1_wdata(c1),
		.latch_we(lw), .latch_port(cp), .latch_wdata(la), .dis_we(dw), .dis_wdata(ds),
		.pin_in, .three_port(op[3]), .ext_clock_in(op[2]), .crystal(op[1]),
		.ext_reset_en(op[0]), .pin_oe(oe), .pin_out(out), .pin_weak_hi(wk), .pin_rd(rd),
		.cfg0_rd(r0), .cfg1_rd(r1), .port0_digital_input_disable(dr), .io_pin_count(cnt));
	task chk(input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %0t %h %h", $time, e, g);
		end
	endtask
	task wt;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task wr(input logic [1:0] p, input logic [7:0] a, b, l);
		@(posedge clk);
		{cp, c0, c1, la, cw, lw} <= {p, a, b, l, 2'h3};
		@(posedge clk);
		{cw, lw} <= 2'h0;
		wt;
	endtask
	task rst;
		@(posedge clk);
		reset <= 1;
		repeat (5) @(posedge clk);
		reset <= 0;
		wt;
		chk(32'hFFFFFFFF, r1);
		chk(32'h0, r0 | oe | wk | dr);
		$display("reset done");
	endtask
	task t_types;
		static logic [7:0] eo [4] = '{8'hF0, 8'hFF, 8'h00, 8'hF0};
		static logic [7:0] er [4] = '{8'h00, 8'h0F, 8'hF0, 8'h00};
		for (int t = 0; t < 4; t++) begin
			wr(2'h0, {8{t[0]}}, {8{t[1]}}, 8'h0F);
			chk({eo[t], er[t]}, {oe[7:0], rd[7:0]});
			chk({t ? 8'h00 : 8'h0F, eo[t] & 8'h0F}, {wk[7:0], oe[7:0] & out[7:0]});
		end
		wr(2'h1, 8'hFF, 8'h00, 8'hFF);
		chk(32'hDB00, oe & 32'hFF00);
		wr(2'h1, 8'hFF, 8'hFF, 8'h00);
		chk(32'hDF00, oe & 32'hFF00);
		$display("types done");
	endtask
	task t_dis;
		wr(2'h0, 8'h00, 8'hFF, 8'h00);
		@(posedge clk);
		{ds, dw} <= {8'h30, 1'h1};
		@(posedge clk);
		dw <= 0;
		wt;
		chk(32'hC0, rd & 32'hFF);
		rst;
		$display("disable done");
	endtask
	task t_cnt;
		static logic [3:0] oa [8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h2, 4'h3, 4'h8, 4'h9};
		static logic [3:0] ec [8] = '{4'hC, 4'hB, 4'hB, 4'hA, 4'hA, 4'h9, 4'hC, 4'hB};
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			op <= oa[i];
			wt;
			chk({28'h0, ec[i]}, {28'h0, cnt});
		end
		$display("count done");
	endtask
	task final_report;
		$display("compared %0d failed %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		rst;
		t_types;
		t_dis;
		t_cnt;
		final_report;
	end
endmodule // cio_port_bench
